/* hw/wwdt_pkg.sv */
/*
  Package for the window watchdog: option byte layout, counter sizing and reset values.
  Assumes the option byte is presented as a static value from nonvolatile storage.
*/
package wwdt_pkg;
  localparam int unsigned CNT_W          = 18;
  localparam int unsigned OVF_BASE_LOG2  = 10;
  localparam int unsigned QUARTER_SHIFT  = 2;
  localparam logic [1:0]  FRAC_FULL      = 2'h3;
  localparam logic [CNT_W-1:0] COUNT_RST = 18'h00000;
  localparam logic        FIRST_RST      = 1'b1;

  typedef struct packed {
    logic       counter_enable_option;
    logic [2:0] overflow_select;       // overflow_select_msb .. overflow_select_lsb
    logic [1:0] open_fraction_select;  // open_fraction_select_hi, open_fraction_select_lo
    logic       osc_stop_permit;       // 1: low-speed oscillator may be stopped
  } option_t;

  localparam option_t OPTION_RST = '{1'b0, 3'h0, 2'h0, 1'b0};
endpackage

/* hw/window_watchdog.sv */
/*
  Window watchdog counter advanced by rising edges of the low-speed oscillator.
  Assumes the option byte is steady around reset release and restart_in is a one-cycle
  pulse from logic on sys_clk_in; lsosc_in is asynchronous.
*/
// Overview of operation
// - Option enable bit turns counter on or off
// - Counter advances only on low-speed oscillator rising edges
// - Restart in open window clears counter, no reset
// - Overflow without restart raises internal reset
// - Restart while window closed raises reset
// - Open window is 25, 50, 75 or 100 percent
// - Full window accepts restart any time before overflow
// - Three-bit field selects overflow time
// - Configuration fixed in flash, unchangeable by software
// - Counting starts right at reset release
// - First restart after reset ignores the window
// - Oscillator stop halts watchdog only if permitted
// - Enable bit also enables illegal-access detection
// - Stop request ignored when oscillator is unstoppable
// - Stopped oscillator keeps the count and resumes
`timescale 1ns/1ps
module window_watchdog (
  input  wire logic                     sys_clk_in,
  input  wire logic                     nrst_in,
  input  wire wwdt_pkg::option_t        option_in,
  input  wire logic                     lsosc_in,
  input  wire logic                     restart_in,
  input  wire logic                     osc_stop_request_in,
  input  wire logic                     standby_in,
  output logic                          watchdog_reset_out,
  output logic                          illegal_access_detect_en_out,
  output logic                          osc_running_out,
  output logic                          window_open_out,
  output logic                          first_restart_out,
  output logic [wwdt_pkg::CNT_W-1:0]    count_out
);

  logic                          osc_meta;
  logic                          osc_sync;
  logic                          osc_prev;
  logic                          cfg_valid;
  wwdt_pkg::option_t             cfg;
  logic                          osc_running;
  logic                          first;
  logic [wwdt_pkg::CNT_W-1:0]    count;
  logic                          active;
  logic                          tick;
  logic                          open_now;
  logic                          early;
  logic                          restart_ok;
  logic                          overflow;
  logic [wwdt_pkg::CNT_W-1:0]    lim;
  logic [wwdt_pkg::CNT_W-1:0]    close_lim;

  function automatic logic [wwdt_pkg::CNT_W-1:0] ovf_limit(input logic [2:0] sel);
    ovf_limit = wwdt_pkg::CNT_W'(1) << (wwdt_pkg::OVF_BASE_LOG2 + 32'(sel));
  endfunction

  function automatic logic [wwdt_pkg::CNT_W-1:0] closed_len(input logic [2:0] sel, input logic [1:0] frac);
    logic [wwdt_pkg::CNT_W-1:0] quarter;
    quarter = ovf_limit(sel) >> wwdt_pkg::QUARTER_SHIFT;
    // Closed part is the leading (3-frac) quarters, open part runs to overflow
    closed_len = wwdt_pkg::CNT_W'(quarter * wwdt_pkg::CNT_W'(wwdt_pkg::FRAC_FULL - frac));
  endfunction

  // Two-flop synchroniser on the oscillator pin
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= lsosc_in;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  // Option byte caught once after reset release and held thereafter
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_valid <= 1'b0;
      cfg       <= wwdt_pkg::OPTION_RST;
    end else if (!cfg_valid) begin
      cfg_valid <= 1'b1;
      cfg       <= option_in;
    end
  end

  // Oscillator stops on request or standby only where the option permits
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_running <= 1'b1;
    end else begin
      osc_running <= !(cfg_valid && cfg.osc_stop_permit && (osc_stop_request_in || standby_in));
    end
  end

  assign active     = cfg_valid && cfg.counter_enable_option;
  assign tick       = osc_sync && !osc_prev && osc_running;
  assign lim        = ovf_limit(cfg.overflow_select);
  assign close_lim  = closed_len(cfg.overflow_select, cfg.open_fraction_select);
  assign open_now   = first || (count >= close_lim);
  assign early      = active && restart_in && !open_now;
  assign restart_ok = active && restart_in && open_now;
  assign overflow   = active && !restart_in && tick && (count == lim - wwdt_pkg::CNT_W'(1));

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= wwdt_pkg::COUNT_RST;
    end else if (!active || restart_ok || early || overflow) begin
      count <= wwdt_pkg::COUNT_RST;
    end else if (tick) begin
      count <= count + wwdt_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      first <= wwdt_pkg::FIRST_RST;
    end else if (early || overflow) begin
      first <= 1'b1;
    end else if (restart_ok) begin
      first <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      watchdog_reset_out <= 1'b0;
    end else begin
      watchdog_reset_out <= early || overflow;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      illegal_access_detect_en_out <= 1'b0;
      window_open_out              <= 1'b0;
    end else begin
      illegal_access_detect_en_out <= active;
      window_open_out              <= active && open_now;
    end
  end

  assign osc_running_out   = osc_running;
  assign first_restart_out = first;
  assign count_out         = count;

  sequence s_reset_then_clear;
    watchdog_reset_out ##1 (count == wwdt_pkg::COUNT_RST);
  endsequence

  // Early restart: reset pulse, then first restart re-armed
  sequence s_reset_then_rearm;
    watchdog_reset_out ##1 first;
  endsequence

  property p_disabled;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (cfg_valid && !cfg.counter_enable_option) |=> (count == wwdt_pkg::COUNT_RST) && !watchdog_reset_out;
  endproperty
  a_disabled: assert property (p_disabled) else $error("Disabled watchdog counted or reset");

  property p_overflow;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (active && !restart_in && tick && count == lim - wwdt_pkg::CNT_W'(1)) |=> s_reset_then_clear;
  endproperty
  a_overflow: assert property (p_overflow) else $error("Overflow did not raise reset");

  property p_early;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (active && restart_in && !first && count < close_lim) |=> s_reset_then_rearm;
  endproperty
  a_early: assert property (p_early) else $error("Early restart did not raise reset");

  property p_restart_ok;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (active && restart_in && !first && count >= close_lim) |=> !watchdog_reset_out && count == wwdt_pkg::COUNT_RST;
  endproperty
  a_restart_ok: assert property (p_restart_ok) else $error("Open-window restart mishandled");

  property p_full_window;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (active && cfg.open_fraction_select == wwdt_pkg::FRAC_FULL && restart_in) |=> !watchdog_reset_out;
  endproperty
  a_full_window: assert property (p_full_window) else $error("Full window refused a restart");

  property p_first;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (active && first && restart_in) |=> !watchdog_reset_out && !first;
  endproperty
  a_first: assert property (p_first) else $error("First restart was not accepted");

  property p_hold_stopped;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (active && !osc_running && !restart_in) |=> count == $past(count);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("Count moved while oscillator stopped");

  property p_unstoppable;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (cfg_valid && !cfg.osc_stop_permit) [*2] |-> osc_running;
  endproperty
  a_unstoppable: assert property (p_unstoppable) else $error("Unstoppable oscillator was stopped");

  property p_tick_count;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (active && tick && !restart_in && count != lim - wwdt_pkg::CNT_W'(1)) |=> count == $past(count) + 1'b1;
  endproperty
  a_tick_count: assert property (p_tick_count) else $error("Oscillator edge did not advance count");

  property p_cfg_fixed;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    cfg_valid |=> $stable(cfg);
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed) else $error("Configuration changed after capture");

  // Quarter window: the leading three quarters stay closed
  property p_quarter_closed;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (active && !first && cfg.open_fraction_select == 2'h0 && count < 3 * (lim >> 2)) |=> !window_open_out;
  endproperty
  a_quarter_closed: assert property (p_quarter_closed) else $error("Window open in closed part");

  property p_illegal_en;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    cfg_valid |=> illegal_access_detect_en_out == cfg.counter_enable_option;
  endproperty
  a_illegal_en: assert property (p_illegal_en) else $error("Access detection enable differs from option");

endmodule

/* test/window_watchdog_bench.sv */
/*
  Self-checking bench for the window watchdog, with an integer model of counter and window.
  Assumes the design samples the option byte on the first edge after reset release.
*/
`timescale 1ns/1ps
module window_watchdog_timer_bench;
  logic                              sys_clk_in = 1'b0;
  logic                              nrst_in = 1'b0;
  wwdt_pkg::option_t                 option_in = wwdt_pkg::OPTION_RST;
  logic                              lsosc_in = 1'b0;
  logic                              restart_in = 1'b0;
  logic                              osc_stop_request_in = 1'b0;
  logic                              standby_in = 1'b0;
  logic                              watchdog_reset_out;
  logic                              illegal_access_detect_en_out;
  logic                              osc_running_out;
  logic                              window_open_out;
  logic                              first_restart_out;
  logic [wwdt_pkg::CNT_W-1:0]        count_out;
  int                                count, first, lim, closed, exp_rst, rst_seen, bad_count, cmp_count;
  int                                seed = 74;
  bit                                en, permit, req, stby;

  window_watchdog i_window_watchdog (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .option_in(option_in), .lsosc_in(lsosc_in),
    .restart_in(restart_in), .osc_stop_request_in(osc_stop_request_in), .standby_in(standby_in),
    .watchdog_reset_out(watchdog_reset_out), .illegal_access_detect_en_out(illegal_access_detect_en_out),
    .osc_running_out(osc_running_out), .window_open_out(window_open_out),
    .first_restart_out(first_restart_out), .count_out(count_out));

  always #20 sys_clk_in = ~sys_clk_in;

  // Counts internal reset pulses as they occur
  always @(posedge sys_clk_in) begin
    if (watchdog_reset_out === 1'b1) begin
      rst_seen++;
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // Outputs are read mid-cycle; driving resumes on the next rising edge
  task automatic check();
    @(negedge sys_clk_in);
    cmp(count_out, count, "count");
    cmp(first_restart_out, first, "first restart");
    cmp(rst_seen, exp_rst, "reset pulses");
    cmp(illegal_access_detect_en_out, en, "illegal access enable");
    cmp(osc_running_out, !(permit && (req || stby)), "oscillator running");
    cmp(window_open_out, en && (first != 0 || count >= closed), "window open");
    @(posedge sys_clk_in);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      lsosc_in <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      lsosc_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      if (en && !(permit && (req || stby))) begin
        count++;
        if (count == lim) begin
          count = 0;
          first = 1;
          exp_rst++;
        end
      end
    end
    check();
  endtask

  task automatic restart();
    restart_in <= 1'b1;
    @(posedge sys_clk_in);
    restart_in <= 1'b0;
    @(posedge sys_clk_in);
    if (en) begin
      if (first == 0 && count < closed) begin
        exp_rst++;
      end
      first = (first == 0 && count < closed);
      count = 0;
    end
    check();
  endtask

  task automatic do_reset(input bit e, input bit [1:0] f, input bit [2:0] o);
    option_in <= '{e, o, f, permit};
    nrst_in <= 1'b0;
    repeat (16) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    option_in <= wwdt_pkg::option_t'(7'($random(seed)));
    @(posedge sys_clk_in);
    en = e;
    lim = 1 << (10 + o);
    closed = lim / 4 * (3 - f);
    count = 0;
    first = 1;
    check();
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end
    else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk_in);
    bad_count++;
    $display("wrong value at %0t: run did not finish in time", $time);
    finish_test();
  end

  initial begin
    for (int r = 0; r < 5; r++) begin
      permit = 1'($random(seed));
      do_reset(r != 4, 2'(r), (r == 3) ? 3'h1 : 3'h0);
      tick(5);
      restart();
      tick(closed + ($unsigned($random(seed)) % (lim - closed - 1)));
      restart();
      tick(closed > 0 ? closed - 1 : 0);
      restart();
      req = 1'($random(seed));
      stby = 1'($random(seed));
      osc_stop_request_in <= req;
      standby_in <= stby;
      tick(4);
      restart();
      req = 1'b0;
      stby = 1'b0;
      osc_stop_request_in <= 1'b0;
      standby_in <= 1'b0;
      tick(lim - count);
      $display("test %0d done", r);
    end
    finish_test();
  end
endmodule
